// >>> hdl/mmll_defines.svh
// Constants for the MII transmit side, LED outputs and PHY reset pass-through
// Contract
// - Transmit nibble changes only on transmit clock rise
// - Transmit enable high exactly for valid nibbles
// - Transmit error forces invalid code-groups in frame
// - Receive LED blinks while receiving, else high
// - Collision LED low during collision, else high
// - Link_status_led low when up, blinks on traffic
// - Duplex LED low full duplex, high half
// - PHY held in reset while reset input low
`ifndef MMLL_DEFINES_SVH
`define MMLL_DEFINES_SVH

`define MMLL_TXD_W 4
`define MMLL_CLK_MHZ 200
`define MMLL_BLINK_HALF_MS 50
`define MMLL_US_PER_MS 1000
`define MMLL_BLINK_CNT_W 24
`define MMLL_PHY_RST_MIN_MS 50
`define MMLL_PHY_RST_MAX_MS 150

// Bit positions of the synchronised input vector
`define MMLL_IN_TXCLK 0
`define MMLL_IN_CRS 1
`define MMLL_IN_COL 2
`define MMLL_IN_RXDV 3
`define MMLL_IN_LINK 4
`define MMLL_IN_FDX 5
`define MMLL_IN_PRST 6
`define MMLL_IN_W 7

`define MMLL_LED_ON 1'b0
`define MMLL_LED_OFF 1'b1
`define MMLL_PRST_RESET 1'b0

`endif

// >>> hdl/mmll_pkg.sv
// Types shared by the MII transmit and LED logic
`include "mmll_defines.svh"
package mmll_pkg;

  typedef struct packed
  {
    logic en;
    logic er;
    logic [`MMLL_TXD_W-1:0] txd;
  } mmll_mii_tx_s;

  typedef enum logic [1:0]
  {
    MMLL_TX_IDLE = 2'b01,
    MMLL_TX_BUSY = 2'b10
  } mmll_tx_state_e;

endpackage

// >>> hdl/mmll_sync.sv
// Two-stage synchroniser, one pair of flops per bit
`timescale 1ns/10ps
`include "mmll_defines.svh"
module mmll_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      logic meta_ff;
      logic sync_ff;
      logic nxt_meta;
      logic nxt_sync;

      // First flop feeds only the second one
      always_comb
      begin
        nxt_meta = ce ? d[i] : meta_ff;
        nxt_sync = ce ? meta_ff : sync_ff;
      end

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end
        else
        begin
          meta_ff <= nxt_meta;
          sync_ff <= nxt_sync;
        end
      end

      assign q[i] = sync_ff;
    end
  endgenerate

endmodule

// >>> hdl/mmll_mac_top.sv
// MII transmit driver, status LEDs and embedded PHY reset pass-through
`timescale 1ns/10ps
`include "mmll_defines.svh"
module mmll_mac_top #(
  parameter int BLINK_HALF_CYCLES = `MMLL_BLINK_HALF_MS * `MMLL_US_PER_MS * `MMLL_CLK_MHZ
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic TX_CLK,
  input wire logic CRS,
  input wire logic COL,
  input wire logic RX_DV,
  input wire logic LINK_UP,
  input wire logic FULL_DUPLEX,
  input wire logic PHY_RESET_IN_N,
  input wire logic TX_VALID,
  input wire logic [`MMLL_TXD_W-1:0] TX_DATA,
  input wire logic TX_ERROR,
  output logic TX_TAKEN,
  output logic [`MMLL_TXD_W-1:0] MII_TXD,
  output logic MII_TX_EN,
  output logic MII_TX_ER,
  output logic CARRIER_SENSE,
  output logic RECEIVE_ACTIVITY_LED,
  output logic COLLISION_LED,
  output logic LINK_STATUS_LED,
  output logic DUPLEX_LED,
  output logic INTERNAL_PHY_RESET_N
);

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [`MMLL_IN_W-1:0] pins_raw;
  logic [`MMLL_IN_W-1:0] pins_s;
  logic txclk_s;
  logic crs_s;
  logic col_s;
  logic rxdv_s;
  logic link_s;
  logic fdx_s;
  logic prst_s;

  // Carrier sense and collision are asynchronous to us
  always_comb
  begin
    pins_raw = '0;
    pins_raw[`MMLL_IN_TXCLK] = TX_CLK;
    pins_raw[`MMLL_IN_CRS] = CRS;
    pins_raw[`MMLL_IN_COL] = COL;
    pins_raw[`MMLL_IN_RXDV] = RX_DV;
    pins_raw[`MMLL_IN_LINK] = LINK_UP;
    pins_raw[`MMLL_IN_FDX] = FULL_DUPLEX;
    pins_raw[`MMLL_IN_PRST] = PHY_RESET_IN_N;
  end

  mmll_sync #(
    .W(`MMLL_IN_W)
  ) u_sync (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .ce(CE),
    .d(pins_raw),
    .q(pins_s)
  );

  assign txclk_s = pins_s[`MMLL_IN_TXCLK];
  assign crs_s = pins_s[`MMLL_IN_CRS];
  assign col_s = pins_s[`MMLL_IN_COL];
  assign rxdv_s = pins_s[`MMLL_IN_RXDV];
  assign link_s = pins_s[`MMLL_IN_LINK];
  assign fdx_s = pins_s[`MMLL_IN_FDX];
  assign prst_s = pins_s[`MMLL_IN_PRST];

  // ----------------------------------------
  // Transmit side
  // ----------------------------------------
  logic txclk_prev_ff;
  logic nxt_txclk_prev;
  mmll_pkg::mmll_mii_tx_s tx_ff;
  mmll_pkg::mmll_mii_tx_s nxt_tx;
  mmll_pkg::mmll_tx_state_e tx_state_ff;
  mmll_pkg::mmll_tx_state_e nxt_tx_state;
  logic taken_ff;
  logic nxt_taken;
  logic tx_edge;
  logic tx_step;

  // Outputs move a few system cycles after the PHY edge, well inside its period
  assign tx_edge = txclk_s & ~txclk_prev_ff;
  assign tx_step = tx_edge & CE;

  always_comb
  begin
    nxt_txclk_prev = txclk_s;
    nxt_tx = tx_ff;
    nxt_taken = 1'b0;
    nxt_tx_state = tx_state_ff;
    if (tx_edge)
    begin
      nxt_tx.txd = TX_VALID ? TX_DATA : '0;
      nxt_tx.en = TX_VALID;
      nxt_tx.er = TX_VALID & TX_ERROR;
      nxt_taken = TX_VALID;
      nxt_tx_state = TX_VALID ? mmll_pkg::MMLL_TX_BUSY : mmll_pkg::MMLL_TX_IDLE;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      txclk_prev_ff <= 1'b0;
      tx_ff <= '0;
      taken_ff <= 1'b0;
      tx_state_ff <= mmll_pkg::MMLL_TX_IDLE;
    end
    else if (CE)
    begin
      txclk_prev_ff <= nxt_txclk_prev;
      tx_ff <= nxt_tx;
      taken_ff <= nxt_taken;
      tx_state_ff <= nxt_tx_state;
    end
  end

  // ----------------------------------------
  // Blink timebase and LEDs
  // ----------------------------------------
  logic [`MMLL_BLINK_CNT_W-1:0] blink_cnt_ff;
  logic [`MMLL_BLINK_CNT_W-1:0] nxt_blink_cnt;
  logic blink_ff;
  logic nxt_blink;
  logic tx_busy;
  logic traffic;
  logic crs_ff;
  logic nxt_crs;
  logic receive_activity_led_ff;
  logic nxt_receive_activity_led;
  logic collision_led_ff;
  logic nxt_collision_led;
  logic link_status_led_ff;
  logic nxt_link_status_led;
  logic dup_led_ff;
  logic nxt_dup_led;
  logic prst_ff;
  logic nxt_prst;

  assign tx_busy = (tx_state_ff == mmll_pkg::MMLL_TX_BUSY);
  assign traffic = rxdv_s | crs_s | tx_busy;

  always_comb
  begin
    nxt_blink_cnt = blink_cnt_ff + `MMLL_BLINK_CNT_W'(1'b1);
    nxt_blink = blink_ff;
    if (blink_cnt_ff == `MMLL_BLINK_CNT_W'(BLINK_HALF_CYCLES - 1))
    begin
      nxt_blink_cnt = '0;
      nxt_blink = ~blink_ff;
    end
    nxt_crs = crs_s;
    nxt_receive_activity_led = rxdv_s ? blink_ff : `MMLL_LED_OFF;
    nxt_collision_led = col_s ? `MMLL_LED_ON : `MMLL_LED_OFF;
    // A link that is down wins over traffic
    if (!link_s)
      nxt_link_status_led = `MMLL_LED_OFF;
    else if (traffic)
      nxt_link_status_led = blink_ff;
    else
      nxt_link_status_led = `MMLL_LED_ON;
    nxt_dup_led = fdx_s ? `MMLL_LED_ON : `MMLL_LED_OFF;
    // Straight pass-through; the RC network sets the low time
    nxt_prst = prst_s;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      blink_cnt_ff <= '0;
      blink_ff <= 1'b0;
      crs_ff <= 1'b0;
      receive_activity_led_ff <= `MMLL_LED_OFF;
      collision_led_ff <= `MMLL_LED_OFF;
      link_status_led_ff <= `MMLL_LED_OFF;
      dup_led_ff <= `MMLL_LED_OFF;
      prst_ff <= `MMLL_PRST_RESET;
    end
    else if (CE)
    begin
      blink_cnt_ff <= nxt_blink_cnt;
      blink_ff <= nxt_blink;
      crs_ff <= nxt_crs;
      receive_activity_led_ff <= nxt_receive_activity_led;
      collision_led_ff <= nxt_collision_led;
      link_status_led_ff <= nxt_link_status_led;
      dup_led_ff <= nxt_dup_led;
      prst_ff <= nxt_prst;
    end
  end

  assign TX_TAKEN = taken_ff;
  assign MII_TXD = tx_ff.txd;
  assign MII_TX_EN = tx_ff.en;
  assign MII_TX_ER = tx_ff.er;
  assign CARRIER_SENSE = crs_ff;
  assign RECEIVE_ACTIVITY_LED = receive_activity_led_ff;
  assign COLLISION_LED = collision_led_ff;
  assign LINK_STATUS_LED = link_status_led_ff;
  assign DUPLEX_LED = dup_led_ff;
  assign INTERNAL_PHY_RESET_N = prst_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  a_txd_edge_only: assert property ($changed(MII_TXD) |-> $past(tx_step))
    else $error("Transmit nibble moved without a transmit clock edge");
  a_txen_follows_valid: assert property (tx_step |=> MII_TX_EN == $past(TX_VALID))
    else $error("Transmit enable does not match offered data");
  a_txen_holds: assert property ($changed(MII_TX_EN) |-> $past(tx_step))
    else $error("Transmit enable moved between edges");
  a_txer_in_frame: assert property (tx_step && TX_VALID && TX_ERROR |=> MII_TX_ER && MII_TX_EN)
    else $error("Transmit error not driven inside frame");
  a_txer_only_frame: assert property (MII_TX_ER |-> MII_TX_EN)
    else $error("Transmit error high outside a frame");
  a_crs_sync_copy: assert property (CE |=> CARRIER_SENSE == $past(crs_s))
    else $error("Carrier sense output not the synchronised copy");
  a_receive_activity_led_idle: assert property (CE && !rxdv_s |=> RECEIVE_ACTIVITY_LED)
    else $error("Receive LED not high while idle");
  a_receive_activity_led_blink: assert property (CE && rxdv_s |=> RECEIVE_ACTIVITY_LED == $past(blink_ff))
    else $error("Receive LED not following blink");
  a_collision_led_level: assert property (CE |=> COLLISION_LED == !$past(col_s))
    else $error("Collision LED level wrong");
  a_link_status_led_steady: assert property (CE && link_s && !traffic |=> !LINK_STATUS_LED)
    else $error("Link_status_led not steady low on idle link");
  a_duplex_led_mode: assert property (CE |=> DUPLEX_LED == !$past(fdx_s))
    else $error("Duplex LED level wrong");
  a_phy_reset_hold: assert property (CE && !prst_s |=> !INTERNAL_PHY_RESET_N)
    else $error("Embedded PHY released while reset input low");
  a_col_sync_delay: assert property ((CE && COL) ##1 CE ##1 CE |=> !COLLISION_LED)
    else $error("Collision not seen three cycles after pin");

  c_tx_frame: cover property (tx_step && TX_VALID ##[1:40] tx_step && !TX_VALID);
  c_tx_error: cover property (MII_TX_ER && MII_TX_EN);
  c_collision: cover property (!COLLISION_LED);
  c_link_blink: cover property (link_s && traffic && LINK_STATUS_LED);

endmodule

// >>> testbench/mmll_phy_model.sv
// Behavioural PHY facing the MII transmit side
`timescale 1ns/10ps
module mmll_phy_model (
  input wire logic run,
  input wire logic rx_on,
  input wire logic col_on,
  input wire logic tx_en,
  input wire logic tx_er,
  input wire logic rx_bad,
  output logic rx_er,
  output logic tx_clk,
  output logic crs,
  output logic col,
  output logic rx_dv,
  output int bad_codes
);
  // ----------
  // Link side
  // ----------
  initial bad_codes = 0;
  // Offset keeps clock edges away from the system clock edges
  initial
  begin
    tx_clk = 1'b0;
    #1.1;
    forever #62.5 tx_clk = run ? ~tx_clk : 1'b0;
  end
  assign crs = rx_on | tx_en;
  assign col = col_on;
  assign rx_dv = rx_on;
  // Error flag only ever inside a reception
  assign rx_er = rx_on & rx_bad;
  // Error nibble becomes an invalid code-group
  always @(posedge tx_clk)
    if (tx_en && tx_er)
      bad_codes <= bad_codes + 1;
endmodule

// >>> testbench/mmll_mac_top_tb_top.sv
// Self-checking bench for the MII transmit driver and status LEDs
`timescale 1ns/10ps
module mmll_mac_top_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0;
  logic [3:0] dat = 4'h0;
  logic err = 1'b0;
  logic prst_in = 1'b1;
  logic lnk = 1'b0;
  logic fdx = 1'b0;
  logic run = 1'b0;
  logic rx_on = 1'b0;
  logic col_on = 1'b0;
  logic ce = 1'b1;
  logic rx_bad = 1'b0;
  logic tclk, crs, col, rxdv, taken, en, er, cs, rxl, coll, lnkl, dxl, prst, rxer;
  logic [3:0] txd;
  logic [3:0] txd_p = 4'h0;
  logic tclk_p = 1'b0;
  logic [7:0] lfsr = 8'h61;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int since = 99;
  int bad, k, t, nerr;
  mmll_pkg::mmll_mii_tx_s e;
  mmll_pkg::mmll_mii_tx_s exp_q[$];
  always #2.5 clk = ~clk;
  mmll_mac_top #(.BLINK_HALF_CYCLES(8)) mmll_mac_top_i (.CLK_SYS(clk), .RESET_N(rst_n),
    .CE(ce), .TX_CLK(tclk), .CRS(crs), .COL(col), .RX_DV(rxdv), .LINK_UP(lnk),
    .FULL_DUPLEX(fdx), .PHY_RESET_IN_N(prst_in), .TX_VALID(vld), .TX_DATA(dat),
    .TX_ERROR(err), .TX_TAKEN(taken), .MII_TXD(txd), .MII_TX_EN(en), .MII_TX_ER(er),
    .CARRIER_SENSE(cs), .RECEIVE_ACTIVITY_LED(rxl), .COLLISION_LED(coll),
    .LINK_STATUS_LED(lnkl), .DUPLEX_LED(dxl), .INTERNAL_PHY_RESET_N(prst));
  mmll_phy_model mmll_phy_model_i (.run(run), .rx_on(rx_on), .col_on(col_on), .tx_en(en),
    .tx_er(er), .rx_bad(rx_bad), .rx_er(rxer), .tx_clk(tclk), .crs(crs), .col(col),
    .rx_dv(rxdv), .bad_codes(bad));
  // ----------
  // Helpers
  // ----------
  task automatic chk(input logic [5:0] got, input logic [5:0] ex, input string m);
    tests_run++;
    if (got !== ex)
    begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic chk_tx(input mmll_pkg::mmll_mii_tx_s got, input mmll_pkg::mmll_mii_tx_s ex,
    input string m);
    chk(got, ex, m);
  endtask
  function automatic logic [7:0] lfsr_step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Counts level changes of one LED over 64 cycles
  task automatic watch(input logic use_rx, output int c);
    logic p;
    p = use_rx ? rxl : lnkl;
    c = 0;
    repeat (64)
    begin
      @(negedge clk);
      c += int'((use_rx ? rxl : lnkl) !== p);
      p = use_rx ? rxl : lnkl;
    end
  endtask
  task automatic send(input logic [3:0] d, input logic r);
    int i;
    @(negedge clk);
    vld = 1'b1;
    dat = d;
    err = r;
    exp_q.push_back({1'b1, r, d});
    for (i = 0; i < 60 && taken !== 1'b1; i++)
      @(negedge clk);
    chk({5'h0, taken}, 6'h1, "nibble not taken");
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  // ----------
  // Output watcher
  // ----------
  always @(negedge clk)
  begin
    tclk_p <= tclk;
    since <= (tclk && !tclk_p) ? 0 : since + 1;
    txd_p <= txd;
    if (txd !== txd_p && since > 6)
      chk(6'h1, 6'h0, "nibble moved off clock rise");
    if (er === 1'b1)
      chk({5'h0, en}, 6'h1, "error without enable");
    if (taken === 1'b1)
    begin
      e = exp_q.pop_front();
      chk_tx({en, er, txd}, e, "nibble");
    end
  end
  // ----------
  // Scenarios
  // ----------
  initial
  begin
    w(4);
    chk({rxl, coll, lnkl, dxl, prst, 1'b0}, 6'h3C, "reset values");
    rst_n = 1'b1;
    w(4);
    chk({5'h0, prst}, 6'h1, "phy reset released");
    prst_in = 1'b0;
    w(3);
    chk({5'h0, prst}, 6'h0, "phy reset held");
    prst_in = 1'b1;
    col_on = 1'b1;
    w(2);
    chk({5'h0, coll}, 6'h1, "collision early");
    w(1);
    chk({5'h0, coll}, 6'h0, "collision led");
    col_on = 1'b0;
    w(3);
    chk({5'h0, coll}, 6'h1, "collision led off");
    // Enable low must freeze the synchronisers and the LED
    ce = 1'b0;
    col_on = 1'b1;
    w(6);
    chk({5'h0, coll}, 6'h1, "collision led frozen");
    ce = 1'b1;
    w(3);
    chk({5'h0, coll}, 6'h0, "collision led after enable");
    col_on = 1'b0;
    w(3);
    chk({5'h0, coll}, 6'h1, "collision led off again");
    for (k = 0; k < 2; k++)
    begin
      fdx = k[0];
      w(3);
      chk({5'h0, dxl}, {5'h0, ~k[0]}, "duplex led");
    end
    lnk = 1'b1;
    w(3);
    watch(1'b0, t);
    chk({lnkl, 5'(t)}, 6'h0, "link idle");
    // Receive errors must not stop the activity indication
    rx_on = 1'b1;
    rx_bad = 1'b1;
    w(4);
    chk({5'h0, cs}, 6'h1, "carrier sense copy high");
    chk({5'h0, rxer}, 6'h1, "receive error flagged");
    watch(1'b1, t);
    chk({5'h0, t >= 7 && t <= 9}, 6'h1, "receive blink");
    watch(1'b0, t);
    chk({5'h0, t >= 7 && t <= 9}, 6'h1, "link blink");
    rx_on = 1'b0;
    rx_bad = 1'b0;
    w(4);
    chk({4'h0, rxl, lnkl}, 6'h2, "traffic over");
    chk({5'h0, cs}, 6'h0, "carrier sense copy low");
    run = 1'b1;
    nerr = 0;
    // Random nibbles, error on about a quarter of them
    for (k = 0; k < 12; k++)
    begin
      lfsr = lfsr_step(lfsr);
      nerr += int'(lfsr[7] & lfsr[6]);
      send(lfsr[3:0], lfsr[7] & lfsr[6]);
    end
    @(negedge clk);
    vld = 1'b0;
    w(60);
    chk({en, er, txd}, 6'h0, "frame end");
    chk(6'(bad), 6'(nerr), "error code-groups");
    run = 1'b0;
    print_verdict();
  end
endmodule
